// *** hdl/standby_halt_hold_control.v ***
// standby mode control, reset priority and release sequencing
// assumes synchronous port A pins, halt pulse from the instruction decoder
`timescale 1ns/1ps
`include "standby_halt_hold_map.vh"

// What this block does
// - halt with hold high and port A low enters light standby
// - halt with hold high and any port A pin high is a no-op
// - both standby modes stop the system clock and all activity
// - light standby keeps I/O ports as they were
// - entering standby loads the timer with all ones
// - entry clears both interrupt flags, keeps carry and zero
// - interrupts are ignored in standby and never wake it
// - registers, RAM, latches and program counter are retained
// - halt with hold low enters deep standby regardless of port A
// - deep standby blocks inputs, floats bidirectionals, drivers off
// - deep standby ignores interrupt and reset pins, keeps latches
// - hold level is bit 0 of pseudo port at pointer 0EH, branch only
// - branch-if-high on pseudo hold bit branches when hold is high
// - reset low ends light standby; execution resumes on release
// - hold going low in light standby moves to deep standby
// - deep standby ends only by hold high while reset low
// - leaving deep standby keeps RAM, resets PC, ports, registers
// - reset pin is ignored while hold is low, also at power-up
// - after any reset execution starts at address 000H
// - reset clears control register, interrupt flags and output drivers
module standby_halt_hold_control (
  // clock and chip reset
  input wire clk,
  input wire rstn,
  // hold and reset pins from power-fail circuit, port A and interrupt pins
  input wire holdPin,
  input wire systemInitPinN,
  input wire [3:0] lowThreshPort,
  input wire extIrqPin,
  // core handshake
  input wire haltExec,
  input wire [3:0] lowPointer,
  input wire branchIfLineHigh,
  input wire branchIfLineLow,
  input wire portReadInstr,
  input wire extIrqSet,
  input wire timerIrqSet,
  input wire [3:0] ctrlWrData,
  input wire ctrlWrEn,
  input wire [17:0] portLatchIn,
  input wire portLatchWr,
  input wire [10:0] pcNextIn,
  input wire carryIn,
  input wire zeroIn,
  input wire flagWr,
  // state outputs
  output reg sysClkEn,
  output reg lightStandby,
  output reg deepStandby,
  output reg coreReset,
  output reg haltAsNop,
  output reg timerLoad,
  output reg [7:0] timerLoadValue,
  output reg externalIrqFlag,
  output reg timerIrqFlag,
  output reg carryFlag,
  output reg zeroFlag,
  output reg [3:0] ctrlReg,
  output reg [10:0] pcReg,
  output reg [17:0] portLatch,
  output reg inputBlock,
  output reg bidirFloat,
  output reg highSideOff,
  output reg branchTaken,
  output reg pseudoPortValue
);

localparam ST_RUN = 2'd0;
localparam ST_LIGHT = 2'd1;
localparam ST_DEEP = 2'd2;
localparam ST_RESET = 2'd3;

reg holdMeta;
reg holdSync;
reg initMeta;
reg initSyncN;
reg [1:0] state_reg;
reg [1:0] state_next;

// pseudo port select decode, used by both branch forms
function isPseudo;
  input [3:0] ptr;
  begin
    isPseudo = (ptr == `PSEUDO_PORT_SEL);
  end
endfunction

// two-stage pin synchronisers
always @(posedge clk) begin
  if (!rstn) begin
    // idle high, else release looks like a hold drop
    holdMeta <= 1'b1;
    holdSync <= 1'b1;
    initMeta <= 1'b0;
    initSyncN <= 1'b0;
  end else begin
    holdMeta <= holdPin;
    holdSync <= holdMeta;
    initMeta <= systemInitPinN;
    initSyncN <= initMeta;
  end
end

wire resetReq = !initSyncN && holdSync;
wire haltOk = haltExec && state_reg == ST_RUN;

always @* begin
  state_next = state_reg;
  case (state_reg)
    ST_RUN: begin
      if (resetReq) begin
        state_next = ST_RESET;
      end else if (haltOk && !holdSync) begin
        state_next = ST_DEEP;
      end else if (haltOk && lowThreshPort == 4'h0) begin
        state_next = ST_LIGHT;
      end
    end
    ST_LIGHT: begin
      if (!holdSync) begin
        state_next = ST_DEEP;
      end else if (!initSyncN) begin
        state_next = ST_RESET;
      end
    end
    ST_DEEP: begin
      // reset pin alone has no effect here
      if (holdSync && !initSyncN) begin
        state_next = ST_RESET;
      end
    end
    default: begin
      if (initSyncN || !holdSync) begin
        state_next = holdSync ? ST_RUN : ST_DEEP;
      end
    end
  endcase
end

wire enterStandby = state_reg == ST_RUN &&
  (state_next == ST_LIGHT || state_next == ST_DEEP);
wire running = state_reg == ST_RUN && state_next == ST_RUN;

always @(posedge clk) begin
  if (!rstn) begin
    state_reg <= ST_RESET;
    sysClkEn <= 1'b0;
    lightStandby <= 1'b0;
    deepStandby <= 1'b0;
    coreReset <= 1'b1;
    haltAsNop <= 1'b0;
    timerLoad <= 1'b0;
    timerLoadValue <= 8'h00;
    externalIrqFlag <= 1'b0;
    timerIrqFlag <= 1'b0;
    carryFlag <= 1'b0;
    zeroFlag <= 1'b0;
    ctrlReg <= `CTRL_RESET;
    pcReg <= `PC_RESET;
    portLatch <= `PORT_LATCH_RESET;
    inputBlock <= 1'b0;
    bidirFloat <= 1'b0;
    highSideOff <= 1'b1;
    branchTaken <= 1'b0;
    pseudoPortValue <= 1'b0;
  end else begin
    state_reg <= state_next;
    sysClkEn <= state_next == ST_RUN;
    lightStandby <= state_next == ST_LIGHT;
    deepStandby <= state_next == ST_DEEP;
    coreReset <= state_next == ST_RESET;
    haltAsNop <= haltOk && holdSync && !resetReq &&
      lowThreshPort != 4'h0;
    timerLoad <= enterStandby;
    timerLoadValue <= `TIMER_STANDBY_LOAD;
    // deep standby isolates I/O, light keeps it as is
    inputBlock <= state_next == ST_DEEP;
    bidirFloat <= state_next == ST_DEEP;
    highSideOff <= state_next == ST_DEEP || state_next == ST_RESET;
    pseudoPortValue <= holdSync;
    branchTaken <= 1'b0;
    if (state_next == ST_RESET) begin
      // RAM is outside this block and untouched
      ctrlReg <= `CTRL_RESET;
      externalIrqFlag <= 1'b0;
      timerIrqFlag <= 1'b0;
      pcReg <= `PC_RESET;
      portLatch <= `PORT_LATCH_RESET;
    end else if (enterStandby) begin
      externalIrqFlag <= 1'b0;
      timerIrqFlag <= 1'b0;
    end else if (running) begin
      // interrupt sources only act while running
      externalIrqFlag <= externalIrqFlag | extIrqSet;
      timerIrqFlag <= timerIrqFlag | timerIrqSet;
      if (ctrlWrEn) begin
        ctrlReg <= ctrlWrData;
      end
      if (flagWr) begin
        carryFlag <= carryIn;
        zeroFlag <= zeroIn;
      end
      if (portLatchWr) begin
        portLatch <= portLatchIn;
      end
      pcReg <= pcNextIn;
      // port read never sees the pseudo hold bit
      if (isPseudo(lowPointer) && !portReadInstr) begin
        if (branchIfLineHigh) begin
          branchTaken <= holdSync;
        end else if (branchIfLineLow) begin
          branchTaken <= !holdSync;
        end
      end
    end
    // other cases hold pc, latches, flags, ctrl
  end
end

endmodule

// *** hdl/standby_halt_hold_map.vh ***
// constants for the standby and reset sequencing block
// assumes inclusion by the control module only
`ifndef STANDBY_HALT_HOLD_MAP_VH
`define STANDBY_HALT_HOLD_MAP_VH
`define PSEUDO_PORT_SEL 4'hE
`define PSEUDO_HOLD_BIT 0
`define TIMER_STANDBY_LOAD 8'hFF
`define PC_RESET 11'h000
`define CTRL_RESET 4'h0
`define PORT_LATCH_RESET 18'h00000
`define OSC_STABLE_MS 10
`endif

// *** verif/power_fail_model.sv ***
// model of the outside power-fail and reset circuit
// assumes the bench drives powerOk and resetReq just after a clock edge
`timescale 1ns/1ps
module power_fail_model #(parameter STAB = 20) (
  // clock
  input wire clk,
  // requests from bench
  input wire powerOk,
  input wire resetReq,
  // pins to device
  output reg holdPin,
  output reg systemInitPinN
);
  integer cnt = 0;
  initial holdPin = 1'h1;
  initial systemInitPinN = 1'h0;
  always @(posedge clk) begin
    holdPin <= powerOk;
    cnt <= (!powerOk || resetReq) ? STAB : (cnt > 0 ? cnt - 1 : 0);
    // reset stretched past hold rising; never released mid-halt
    systemInitPinN <= powerOk && !resetReq && cnt == 0;
  end
endmodule

// *** verif/standby_halt_hold_asserts.sv ***
// port checker for the standby control block
// assumes bind onto the control module
`timescale 1ns/1ps
module standby_halt_hold_asserts (
  // clock and reset
  input wire clk,
  input wire rstn,
  // inputs
  input wire haltExec,
  input wire [3:0] lowThreshPort,
  // outputs
  input wire pseudoPortValue,
  input wire sysClkEn,
  input wire lightStandby,
  input wire deepStandby,
  input wire coreReset,
  input wire haltAsNop,
  input wire [7:0] timerLoadValue,
  input wire externalIrqFlag,
  input wire timerIrqFlag,
  input wire [17:0] portLatch,
  input wire [10:0] pcReg,
  input wire inputBlock,
  input wire highSideOff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  light_entry_a: assert property (sysClkEn && haltExec && pseudoPortValue &&
    lowThreshPort == 4'h0 |=> lightStandby && !sysClkEn &&
    timerLoadValue == 8'hFF) else $error("bad light entry");
  halt_nop_a: assert property (sysClkEn && haltExec && pseudoPortValue &&
    |lowThreshPort |=> haltAsNop && sysClkEn) else $error("bad nop");
  deep_entry_a: assert property (sysClkEn && haltExec && !pseudoPortValue
    |=> deepStandby && inputBlock && !sysClkEn) else $error("bad deep");
  irq_clear_a: assert property (lightStandby || deepStandby |->
    !externalIrqFlag && !timerIrqFlag) else $error("flag in standby");
  state_keep_a: assert property (!sysClkEn && !coreReset ##1 !sysClkEn &&
    !coreReset |-> $stable(portLatch) && $stable(pcReg)) else $error("lost");
  reset_init_a: assert property (coreReset ##1 coreReset |->
    pcReg == 11'h000 && portLatch == 18'h00000) else $error("bad init");
  hold_prio_a: assert property ((sysClkEn || deepStandby) &&
    !pseudoPortValue ##1 !pseudoPortValue |-> !coreReset)
    else $error("reset while hold low");
  light_deep_a: assert property (lightStandby && !pseudoPortValue |->
    ##[0:3] (deepStandby || coreReset)) else $error("no deep");
  deep_pins_a: assert property (deepStandby |-> highSideOff &&
    inputBlock) else $error("pins live");
endmodule
bind standby_halt_hold_control standby_halt_hold_asserts chk_i (.*);

// *** verif/standby_halt_hold_control_tb.sv ***
// self-checking bench for the standby control block
// assumes power_fail_model drives the hold and reset pins
`timescale 1ns/1ps
module standby_halt_hold_control_tb;
  logic clk, rstn = 0, powerOk = 1, resetReq = 0, run = 0, haltExec = 0;
  logic extIrqPin, branchIfLineHigh = 0, branchIfLineLow, portReadInstr = 0;
  logic extIrqSet, timerIrqSet, ctrlWrEn, portLatchWr, carryIn, zeroIn;
  logic flagWr;
  logic [3:0] lowThreshPort = 0, lowPointer, ctrlWrData;
  logic [17:0] portLatchIn;
  logic [10:0] pcNextIn;
  wire holdPin, systemInitPinN, sysClkEn, lightStandby, deepStandby;
  wire coreReset, haltAsNop, timerLoad, externalIrqFlag, timerIrqFlag;
  wire carryFlag, zeroFlag, inputBlock, bidirFloat, highSideOff;
  wire branchTaken, pseudoPortValue;
  wire [7:0] timerLoadValue;
  wire [3:0] ctrlReg;
  wire [10:0] pcReg;
  wire [17:0] portLatch;
  integer seed = 32'h617f7b3d, fails = 0, cmp_count = 0, cycles = 0;
  logic [17:0] expLatch = 0;
  logic [63:0] r = 0;
  standby_halt_hold_control uut (.*);
  power_fail_model pfm (.*);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles > 6000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [17:0] e, input [17:0] s, input [63:0] n);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("[ERR] %0s exp %h got %h", n, e, s);
      end
    end
  endtask
  // one cycle of random core traffic plus chosen halt and branch
  task cyc(input h, input [3:0] pa, input [1:0] b);
    begin
      {lowPointer, ctrlWrData, pcNextIn, portLatchIn} = r[36:0];
      {ctrlWrEn, carryIn, zeroIn, flagWr, extIrqSet, timerIrqSet} = r[42:37];
      {extIrqPin, branchIfLineLow} = {r[43], r[44] & ~|b};
      portLatchWr = r[45] & run;
      if (portLatchWr) expLatch = portLatchIn;
      if (b != 0) lowPointer = 4'hE;
      {branchIfLineHigh, portReadInstr, haltExec, lowThreshPort} = {b, h, pa};
      @(posedge clk);
      #1;
      r = {$random(seed), $random(seed)};
    end
  endtask
  task wr;
    begin
      run = 0;
      repeat (300) if (sysClkEn !== 1'h1) cyc(0, 0, 0);
      run = 1;
      chk(1, sysClkEn, "run");
      chk(0, {pcReg, ctrlReg, externalIrqFlag, timerIrqFlag}, "pc");
      chk(0, portLatch, "latch");
      expLatch = 0;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    wr;
    repeat (20) cyc(0, 0, 0);
    for (int k = 2; k < 4; k++) begin
      cyc(0, 0, k[1:0]);
      chk(k == 2, branchTaken, "branch");
      cyc(0, 0, 0);
    end
    cyc(1, 4'h5, 0);
    chk(3, {haltAsNop, sysClkEn}, "nop");
    run = 0;
    cyc(1, 0, 0);
    chk(12'hBFC, {lightStandby, sysClkEn, timerLoadValue, externalIrqFlag,
      timerIrqFlag}, "light");
    repeat (12) cyc(0, 0, 0);
    chk(expLatch, portLatch, "hold");
    chk(0, {externalIrqFlag, timerIrqFlag}, "irq");
    resetReq = 1;
    repeat (3) cyc(0, 0, 0);
    resetReq = 0;
    wr;
    powerOk = 0;
    repeat (6) cyc(0, 0, 0);
    chk(1, sysClkEn, "nohold");
    run = 0;
    cyc(1, 4'hF, 0);
    chk(4'hF, {deepStandby, inputBlock, bidirFloat, highSideOff}, "deep");
    repeat (12) cyc(0, 0, 0);
    chk(expLatch, portLatch, "deepkeep");
    powerOk = 1;
    wr;
    run = 0;
    cyc(1, 0, 0);
    powerOk = 0;
    repeat (6) cyc(0, 0, 0);
    chk(3, {deepStandby, highSideOff}, "todeep");
    powerOk = 1;
    wr;
    print_verdict;
  end
endmodule
